//--- edas_pkg.sv
// package for the external data access stretch block
// assumes an aclk-driven core model and an AXI4-Lite master
// ====================================================
// constants and types
package edas_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_PTR_SEL  = 10'h086;
	localparam logic [9:0] IDX_CLK_CTRL = 10'h08e;
	localparam logic [9:0] IDX_DP0      = 10'h090;
	localparam logic [9:0] IDX_DP1      = 10'h091;
	localparam logic [9:0] IDX_PORT2    = 10'h092;
	localparam logic [9:0] IDX_INDEX    = 10'h093;
	localparam logic [9:0] IDX_WDATA    = 10'h094;
	localparam logic [9:0] IDX_CMD      = 10'h095;
	localparam logic [9:0] IDX_STATUS   = 10'h096;
	// field positions
	localparam int STRETCH_LSB  = 0;
	localparam int CMD_WR_BIT   = 0;
	localparam int CMD_PTR_BIT  = 1;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_RD_LSB  = 8;
	// reset values
	localparam logic [7:0] CLK_CTRL_RST = 8'h01;
	localparam logic [7:0] PTR_SEL_RST  = 8'h00;
	// timing counts in clocks
	localparam logic [1:0] PHASE_LAST   = 2'h3;
	localparam logic [5:0] STB_START_0  = 6'h01;
	localparam logic [5:0] STB_LEN_0    = 6'h02;
	localparam logic [5:0] STB_START_N  = 6'h02;
	// bus responses
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {EDAS_IDLE, EDAS_FETCH, EDAS_ACCESS} edas_state_t;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_PSEL, SEL_CLOCK_CONTROL, SEL_DP0, SEL_DP1,
		SEL_P2, SEL_IDX, SEL_WDATA, SEL_CMD, SEL_STAT
	} edas_sel_t;

	// external memory pins
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  dout;
		logic        data_oe;
		logic        rd_n;
		logic        wr_n;
	} edas_ext_t;
endpackage : edas_pkg

//--- edas_stretch.sv
// external data move path: address forming, pointer select, stretched strobes
// assumes off-chip memory on the ext pins, registers reached over AXI4-Lite
//
// Behaviour
// - indirect form drives low address byte from the index register.
// - indirect form drives high address byte from the port 2 latch.
// - pointer form takes full 16-bit address from the selected pointer.
// - pointer select bit is bit zero of register at 86h.
// - select 0 uses first pointer, 1 uses second pointer.
// - other select bits read zero, so increment toggles selection.
// - a move opens with a four-clock opcode fetch machine cycle.
// - next machine cycle presents address and performs the access.
// - stretch value is bits 2 to 0 of clock control.
// - stretch n gives a move of n plus two machine cycles.
// - stretch lengthens only the external data move.
// - stretch resets to 1, three-cycle moves; 0 gives two cycles.
// - strobe lasts 2 clocks at 0, then four clocks per stretch step.
// - machine cycle is four states in fixed order.
// - strobe widens with the added machine cycles.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module edas_stretch (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output      logic [1:0]  s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	// external data memory pins
	output      edas_pkg::edas_ext_t ext_o,
	input  wire logic [7:0]  ext_din
);
	// ====================================================
	// state
	typedef struct packed {
		edas_pkg::edas_state_t st;
		logic [1:0]  phase;
		logic [5:0]  cnt;
		logic        pend;
		logic        dir_wr;
		logic        ptr_form;
		logic [2:0]  n;
		logic [7:0]  psel;
		logic [7:0]  clock_control;
		logic [7:0]  p2;
		logic [7:0]  idx;
		logic [7:0]  wdat;
		logic [7:0]  rdat;
		logic [15:0] dp0;
		logic [15:0] dp1;
		logic [15:0] addr;
		logic [7:0]  dout;
		logic        doe;
		logic        rd_n;
		logic        wr_n;
		logic        aw_full;
		logic [11:0] aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  din_s1;
		logic [7:0]  din_s2;
	} edas_regs_t;

	edas_regs_t q;
	edas_regs_t d;
	logic [15:0] sel_ptr;
	logic        busy;
	logic        stb_d;
	edas_pkg::edas_sel_t wsel;
	edas_pkg::edas_sel_t rsel;

	// ====================================================
	// helpers
	function automatic edas_pkg::edas_sel_t decode(input logic [11:0] a);
		logic [9:0] w;
		w = a[11:2];
		if (w == edas_pkg::IDX_PTR_SEL) decode = edas_pkg::SEL_PSEL;
		else if (w == edas_pkg::IDX_CLK_CTRL) decode = edas_pkg::SEL_CLOCK_CONTROL;
		else if (w == edas_pkg::IDX_DP0) decode = edas_pkg::SEL_DP0;
		else if (w == edas_pkg::IDX_DP1) decode = edas_pkg::SEL_DP1;
		else if (w == edas_pkg::IDX_PORT2) decode = edas_pkg::SEL_P2;
		else if (w == edas_pkg::IDX_INDEX) decode = edas_pkg::SEL_IDX;
		else if (w == edas_pkg::IDX_WDATA) decode = edas_pkg::SEL_WDATA;
		else if (w == edas_pkg::IDX_CMD) decode = edas_pkg::SEL_CMD;
		else if (w == edas_pkg::IDX_STATUS) decode = edas_pkg::SEL_STAT;
		else decode = edas_pkg::SEL_NONE;
	endfunction : decode

	// strobe width in clocks for a stretch value
	function automatic logic [5:0] stb_len(input logic [2:0] n);
		stb_len = (n == 3'h0) ? edas_pkg::STB_LEN_0 : {1'b0, n, 2'b00};
	endfunction : stb_len

	function automatic logic [5:0] stb_first(input logic [2:0] n);
		stb_first = (n == 3'h0) ? edas_pkg::STB_START_0 : edas_pkg::STB_START_N;
	endfunction : stb_first

	// ====================================================
	// outputs
	assign sel_ptr = q.psel[0] ? q.dp1 : q.dp0;
	assign busy = q.pend || (q.st != edas_pkg::EDAS_IDLE);
	assign s_axi_awready = !q.aw_full && !q.bvalid;
	assign s_axi_wready = !q.w_full && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign ext_o = '{addr: q.addr, dout: q.dout, data_oe: q.doe, rd_n: q.rd_n, wr_n: q.wr_n};

	// ====================================================
	// next state
	always_comb begin
		d = q;
		wsel = decode(q.aw_addr);
		rsel = decode(s_axi_araddr);
		// pin data passes two flops before use
		d.din_s1 = ext_din;
		d.din_s2 = q.din_s1;
		d.phase = q.phase + 2'h1;
		// bus write channels are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_full && q.w_full && !q.bvalid) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = edas_pkg::RESP_OKAY;
			if (wsel == edas_pkg::SEL_PSEL) begin
				if (q.w_strb[0]) d.psel = {7'h00, q.w_data[0]};
			end else if (wsel == edas_pkg::SEL_CLOCK_CONTROL) begin
				if (q.w_strb[0]) d.clock_control = q.w_data[7:0];
			end else if (wsel == edas_pkg::SEL_DP0) begin
				if (q.w_strb[0]) d.dp0[7:0] = q.w_data[7:0];
				if (q.w_strb[1]) d.dp0[15:8] = q.w_data[15:8];
			end else if (wsel == edas_pkg::SEL_DP1) begin
				if (q.w_strb[0]) d.dp1[7:0] = q.w_data[7:0];
				if (q.w_strb[1]) d.dp1[15:8] = q.w_data[15:8];
			end else if (wsel == edas_pkg::SEL_P2) begin
				if (q.w_strb[0]) d.p2 = q.w_data[7:0];
			end else if (wsel == edas_pkg::SEL_IDX) begin
				if (q.w_strb[0]) d.idx = q.w_data[7:0];
			end else if (wsel == edas_pkg::SEL_WDATA) begin
				if (q.w_strb[0]) d.wdat = q.w_data[7:0];
			end else if (wsel == edas_pkg::SEL_CMD) begin
				// a command while a move runs is dropped
				if (q.w_strb[0] && !busy) begin
					d.pend = 1'b1;
					d.dir_wr = q.w_data[edas_pkg::CMD_WR_BIT];
					d.ptr_form = q.w_data[edas_pkg::CMD_PTR_BIT];
				end
			end else if (wsel != edas_pkg::SEL_STAT) begin
				d.bresp = edas_pkg::RESP_SLVERR;
			end
		end
		// bus read, one cycle after the address is taken
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rresp = edas_pkg::RESP_OKAY;
			d.rdata = 32'h0000_0000;
			if (rsel == edas_pkg::SEL_PSEL) d.rdata[7:0] = q.psel;
			else if (rsel == edas_pkg::SEL_CLOCK_CONTROL) d.rdata[7:0] = q.clock_control;
			else if (rsel == edas_pkg::SEL_DP0) d.rdata[15:0] = q.dp0;
			else if (rsel == edas_pkg::SEL_DP1) d.rdata[15:0] = q.dp1;
			else if (rsel == edas_pkg::SEL_P2) d.rdata[7:0] = q.p2;
			else if (rsel == edas_pkg::SEL_IDX) d.rdata[7:0] = q.idx;
			else if (rsel == edas_pkg::SEL_WDATA) d.rdata[7:0] = q.wdat;
			else if (rsel == edas_pkg::SEL_CMD) d.rdata[1:0] = {q.ptr_form, q.dir_wr};
			else if (rsel == edas_pkg::SEL_STAT) begin
				d.rdata[edas_pkg::STAT_BUSY] = busy;
				d.rdata[edas_pkg::STAT_RD_LSB +: 8] = q.rdat;
			end else d.rresp = edas_pkg::RESP_SLVERR;
		end
		// move sequencer, aligned to machine cycle boundaries
		case (q.st)
			edas_pkg::EDAS_IDLE: begin
				if (q.pend && q.phase == edas_pkg::PHASE_LAST) begin
					d.st = edas_pkg::EDAS_FETCH;
					d.pend = 1'b0;
					// stretch frozen for the whole move
					d.n = q.clock_control[edas_pkg::STRETCH_LSB +: 3];
				end
			end
			edas_pkg::EDAS_FETCH: begin
				if (q.phase == edas_pkg::PHASE_LAST) begin
					d.st = edas_pkg::EDAS_ACCESS;
					d.cnt = 6'h00;
					if (q.ptr_form) d.addr = sel_ptr;
					else d.addr = {q.p2, q.idx};
					d.dout = q.wdat;
					d.doe = q.dir_wr;
				end
			end
			edas_pkg::EDAS_ACCESS: begin
				d.cnt = q.cnt + 6'h01;
				// synchroniser lags two clocks, so take the copy one clock after the strobe;
				// it then holds pin data from inside the strobe, even at stretch 0
				if (!q.dir_wr && q.cnt == stb_first(q.n) + stb_len(q.n)) begin
					d.rdat = q.din_s2;
				end
				// only this state is lengthened by the stretch
				if (q.cnt == {1'b0, q.n, 2'b11}) begin
					d.st = edas_pkg::EDAS_IDLE;
					d.cnt = 6'h00;
					d.doe = 1'b0;
				end
			end
			default: d.st = edas_pkg::EDAS_IDLE;
		endcase
		// strobes from the next count, so pins come straight from flops
		stb_d = (d.st == edas_pkg::EDAS_ACCESS) && (d.cnt >= stb_first(d.n))
			&& (d.cnt < stb_first(d.n) + stb_len(d.n));
		d.rd_n = !(stb_d && !d.dir_wr);
		d.wr_n = !(stb_d && d.dir_wr);
	end

	// ====================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.clock_control <= edas_pkg::CLK_CTRL_RST;
			q.psel <= edas_pkg::PTR_SEL_RST;
			q.rd_n <= 1'b1;
			q.wr_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ====================================================
	// checks
	logic [5:0] chk_stb;
	logic [5:0] chk_mv;
	logic [5:0] chk_len;
	logic [15:0] chk_addr;
	assign chk_len = stb_len(q.n);
	assign chk_addr = q.ptr_form ? sel_ptr : {q.p2, q.idx};

	// strobe and move length counters for the checks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chk_stb <= 6'h00;
			chk_mv <= 6'h00;
		end else begin
			chk_stb <= (!q.rd_n || !q.wr_n) ? chk_stb + 6'h01 : 6'h00;
			chk_mv <= (q.st != edas_pkg::EDAS_IDLE) ? chk_mv + 6'h01 : 6'h00;
		end
	end

	AST_STRETCH_RST: assert property (@(posedge aclk) !aresetn |=> q.clock_control[2:0] == 3'h1)
		else $error("stretch not 1 after reset");
	AST_PHASE_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
		q.phase == 2'h3 |=> q.phase == 2'h0)
		else $error("machine cycle state order broken");
	AST_FETCH_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == edas_pkg::EDAS_IDLE) ##1 (q.st == edas_pkg::EDAS_FETCH)
		|-> (q.st == edas_pkg::EDAS_FETCH)[*4] ##1 (q.st == edas_pkg::EDAS_ACCESS))
		else $error("fetch cycle not four clocks");
	AST_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st == edas_pkg::EDAS_FETCH && q.phase == 2'h3)
		|=> ext_o.addr == $past(chk_addr))
		else $error("access address wrong");
	AST_PSEL_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		q.psel[7:1] == 7'h00)
		else $error("pointer select upper bits set");
	AST_STB_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ext_o.rd_n && ext_o.wr_n) |-> chk_stb == chk_len)
		else $error("strobe width wrong");
	AST_MOVE_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.st != edas_pkg::EDAS_IDLE) ##1 (q.st == edas_pkg::EDAS_IDLE)
		|-> $past(chk_mv) + 6'h01 == {1'b0, q.n + 3'h2, 2'b00} || q.n == 3'h7
			&& $past(chk_mv) == 6'h23)
		else $error("move length wrong");
	AST_NO_OVERLAP: assert property (@(posedge aclk) disable iff (!aresetn)
		!(!ext_o.rd_n && !ext_o.wr_n)
		&& (ext_o.rd_n || !q.dir_wr) && (ext_o.wr_n || q.dir_wr))
		else $error("strobes overlap or wrong direction");
	AST_STB_IN_ACCESS: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ext_o.rd_n || !ext_o.wr_n) |-> q.st == edas_pkg::EDAS_ACCESS)
		else $error("strobe outside access cycle");

	COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) $fell(ext_o.rd_n));
	COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) $fell(ext_o.wr_n));
	COV_MAX: cover property (@(posedge aclk) disable iff (!aresetn)
		q.n == 3'h7 && chk_stb == 6'h1c);
	COV_FAST: cover property (@(posedge aclk) disable iff (!aresetn)
		q.n == 3'h0 && q.st == edas_pkg::EDAS_ACCESS);
endmodule : edas_stretch

//--- edas_mem_model.sv
// partner model: off-chip data memory on the external pins
// assumes active-low strobes and a flop-driven address from the block
`timescale 1ns/1ps
module edas_mem_model (
	// clock
	input  wire logic                aclk,
	// pins of the block
	input  wire edas_pkg::edas_ext_t ext_o,
	output      logic [7:0]          ext_din,
	// last write seen on the pins
	output      logic [15:0]         wr_addr,
	output      logic [7:0]          wr_data
);
	logic [7:0] last_q = 8'h00;
	logic [1:0] hold_q = 2'h0;
	// ====================================================
	// read side: data is a pattern of the address, held two clocks after the strobe
	always @(posedge aclk) begin
		hold_q <= !ext_o.rd_n ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
		last_q <= ext_din;
		if (!ext_o.wr_n) begin
			wr_addr <= ext_o.addr;
			wr_data <= ext_o.dout;
		end
	end
	// released bus toggles each cycle so a stale sample matches the last driven data only on alternate cycles
	assign ext_din = (!ext_o.rd_n || hold_q != 2'h0) ? (ext_o.addr[7:0] ^ ext_o.addr[15:8] ^ 8'h3c) : ~last_q;
endmodule : edas_mem_model

//--- tb_external_data_access_stretch.sv
// testbench: registers over axi4-lite, stretched external data moves
// assumes the memory model on the external pins
`timescale 1ns/1ps
module tb_external_data_access_stretch;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp;
	logic [7:0]  ext_din, wr_data;
	logic [15:0] wr_addr, stb_addr;
	edas_pkg::edas_ext_t ext_o;
	int rd_cnt = 0, wr_cnt = 0, ovl = 0, miscompares = 0, checked = 0;

	edas_stretch dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .ext_o(ext_o), .ext_din(ext_din));
	edas_mem_model mem_u (.aclk(aclk), .ext_o(ext_o), .ext_din(ext_din), .wr_addr(wr_addr), .wr_data(wr_data));

	// ====================================================
	// clock, strobe monitor, watchdog
	initial begin
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (!ext_o.rd_n) rd_cnt <= rd_cnt + 1;
		if (!ext_o.wr_n) wr_cnt <= wr_cnt + 1;
		if (!ext_o.rd_n && !ext_o.wr_n) ovl <= ovl + 1;
		// data driver must be on for a write strobe and off for a read strobe
		if ((!ext_o.wr_n && !ext_o.data_oe) || (!ext_o.rd_n && ext_o.data_oe)) ovl <= ovl + 1;
		if (!ext_o.rd_n || !ext_o.wr_n) stb_addr <= ext_o.addr;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		wrap_up();
	end

	// ====================================================
	// shared tasks
	function automatic logic [11:0] ba(input logic [9:0] i);
		return {i, 2'b00};
	endfunction : ba
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		if (miscompares == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	// ready is sampled at the falling edge, so the handshake is known before the rising edge
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done, w_done, aw_hs, w_hs;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge aclk);
			aw_hs = !aw_done && awready;
			w_hs = !w_done && wready;
			@(posedge aclk);
			if (aw_hs) begin aw_done = 1'b1; awvalid <= 1'b0; end
			if (w_hs) begin w_done = 1'b1; wvalid <= 1'b0; end
		end
		do @(negedge aclk); while (!bvalid);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : axi_rd
	// one move; judges strobe width, exclusivity, address and data
	task automatic run_move(input logic wr, input logic ptr, input logic [2:0] n, input logic [15:0] ea,
		input logic [7:0] wd);
		logic [1:0]  r;
		logic [31:0] s;
		int          t;
		int          rd0;
		int          wr0;
		int          ov0;
		axi_wr(ba(edas_pkg::IDX_CLK_CTRL), {29'h0, n}, r);
		axi_wr(ba(edas_pkg::IDX_WDATA), {24'h0, wd}, r);
		// snapshot the monitor counts rather than clearing them, so each keeps one driver
		rd0 = rd_cnt;
		wr0 = wr_cnt;
		ov0 = ovl;
		axi_wr(ba(edas_pkg::IDX_CMD), {30'h0, ptr, wr}, r);
		chk({30'h0, r}, {30'h0, edas_pkg::RESP_OKAY});
		s = 32'h1;
		for (t = 0; t < 80 && !(s[0] === 1'b0 && rd_cnt + wr_cnt > rd0 + wr0); t++)
			axi_rd(ba(edas_pkg::IDX_STATUS), s, r);
		chk({31'h0, s[0]}, 32'h0);
		chk(wr ? wr_cnt - wr0 : rd_cnt - rd0, (n == 3'h0) ? 32'h2 : {27'h0, n, 2'b00});
		chk(wr ? rd_cnt - rd0 : wr_cnt - wr0, 32'h0);
		chk(ovl - ov0, 32'h0);
		chk({16'h0, stb_addr}, {16'h0, ea});
		if (wr) chk({24'h0, wr_data}, {24'h0, wd});
		else chk({24'h0, s[15:8]}, {24'h0, ea[7:0] ^ ea[15:8] ^ 8'h3c});
	endtask : run_move

	// ====================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(ba(edas_pkg::IDX_CLK_CTRL), d, r);
		chk({29'h0, d[2:0]}, 32'h1);
		axi_rd(ba(edas_pkg::IDX_PTR_SEL), d, r);
		chk(d, 32'h0);
	endtask : t_reset
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(12'h218, 32'hff, r);
		axi_rd(12'h218, d, r);
		chk(d, 32'h1);
		axi_wr(12'h218, d + 32'h1, r);
		axi_rd(12'h218, d, r);
		chk(d, 32'h0);
		axi_wr(ba(edas_pkg::IDX_CLK_CTRL), 32'h5, r);
		axi_rd(ba(edas_pkg::IDX_CLK_CTRL), d, r);
		chk({29'h0, d[2:0]}, 32'h5);
		axi_wr(12'h3fc, 32'h1, r);
		chk({30'h0, r}, {30'h0, edas_pkg::RESP_SLVERR});
		axi_rd(12'h3fc, d, r);
		chk({30'h0, r}, {30'h0, edas_pkg::RESP_SLVERR});
		chk(d, 32'h0);
	endtask : t_regs
	task automatic t_stretch();
		logic [1:0] r;
		axi_wr(ba(edas_pkg::IDX_DP0), 32'h1234, r);
		for (int i = 0; i < 8; i++) run_move(1'b0, 1'b1, i[2:0], 16'h1234, 8'h00);
	endtask : t_stretch
	task automatic t_ptrsel();
		logic [1:0] r;
		axi_wr(ba(edas_pkg::IDX_DP1), 32'hbeef, r);
		axi_wr(12'h218, 32'h1, r);
		run_move(1'b1, 1'b1, 3'h2, 16'hbeef, 8'ha5);
		axi_wr(12'h218, 32'h0, r);
		run_move(1'b0, 1'b1, 3'h1, 16'h1234, 8'h00);
	endtask : t_ptrsel
	task automatic t_indirect();
		logic [1:0] r;
		axi_wr(ba(edas_pkg::IDX_PORT2), 32'h7e, r);
		axi_wr(ba(edas_pkg::IDX_INDEX), 32'h81, r);
		run_move(1'b1, 1'b0, 3'h0, 16'h7e81, 8'h3c);
		run_move(1'b0, 1'b0, 3'h7, 16'h7e81, 8'h00);
	endtask : t_indirect

	// ====================================================
	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_regs();
		t_stretch();
		t_ptrsel();
		t_indirect();
		wrap_up();
	end
endmodule : tb_external_data_access_stretch
